// ### rtl/pcemux_pkg.sv
// Package: register map, reset values and option encodings for the shared port mux
`default_nettype none
package pcemux_pkg;
  localparam logic [11:0] PCEMUX_DATA_OFS = 12'h000;
  localparam logic [11:0] PCEMUX_DIR_OFS = 12'h004;
  localparam logic [11:0] PCEMUX_OUT_OFS = 12'h008;
  localparam logic [11:0] PCEMUX_OPT_OFS = 12'h00C;
  localparam logic [3:0] PCEMUX_DIR_RST = 4'h0;
  localparam logic [3:0] PCEMUX_OUT_RST = 4'h0;
  localparam logic [31:0] PCEMUX_ZERO_WORD = 32'h0000_0000;
  localparam int PCEMUX_SYNC_STAGES = 2;
  localparam int PCEMUX_OPT_AMP_BIT = 0;
  localparam int PCEMUX_OPT_CMP1_BIT = 1;
  localparam int PCEMUX_OPT_CMP2_BIT = 2;
  localparam int PCEMUX_OPT_BIT1_READ_ZERO_OPT_BIT = 3;
  localparam int PCEMUX_OPT_BIT3_READ_ZERO_OPT_BIT = 4;
  localparam int PCEMUX_OPT_PIO_BIT = 5;
  typedef enum logic [1:0] {
    PCEMUX_SRC_PIN,
    PCEMUX_SRC_CMP,
    PCEMUX_SRC_ZERO
  } pcemux_src_t;
endpackage : pcemux_pkg
`default_nettype wire

// ### rtl/pcemux_sync.sv
// Two-flop synchroniser, one per bit
`default_nettype none
module pcemux_sync
  import pcemux_pkg::*;
#(
  parameter int W = 6
)
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // Data
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_r;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta_r <= '0;
      sync_out <= '0;
    end
    else if (clk_en)
    begin
      meta_r <= async_in;
      sync_out <= meta_r;
    end
  end
endmodule // pcemux_sync
`default_nettype wire

// ### rtl/pcemux_top.sv
// Shared 4-bit port with comparator/amplifier read multiplexing, APB slave
// Functional notes
// - Three structures chosen by option inputs only
// - Bit1 read-zero option zeroes bit 1
// - Bit3 read-zero option zeroes bit 3
// - No analog option gives plain port
// - Comparator 1 enabled drives bit 0 read
// - Comparator 2 drives bit 2 read alone or with comparator 1
// - Both comparators, or either one alone
// - Amp plus comparator 1, comparator 2 off, zeroes bits 2,3
// - Amplifier owns pins 3,2,0
// - Read-zero options need an enabled comparator
// - Direction bit one means output
`default_nettype none
module pcemux_top
  import pcemux_pkg::*;
(
  // Clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Build options, static after reset
  input wire logic amp_enable_opt,
  input wire logic cmp1_enable_opt,
  input wire logic cmp2_enable_opt,
  input wire logic bit1_read_zero_opt,
  input wire logic bit3_read_zero_opt,
  input wire logic shared_port_io_opt,
  // Analog block outputs
  input wire logic cmp1_out,
  input wire logic cmp2_out,
  // Shared pins
  input wire logic [3:0] shared_pin_in,
  output logic [3:0] shared_pin_out,
  output logic [3:0] shared_pin_oe,
  // Analog enables toward the analog macro
  output logic amp_active,
  output logic cmp1_active,
  output logic cmp2_active
);
  logic [5:0] sync_in;
  logic [5:0] sync_q;
  logic [3:0] pin_s;
  logic cmp1_s;
  logic cmp2_s;
  logic [3:0] shared_port_direction_r;
  logic [3:0] shared_port_data_r;
  logic [3:0] shared_port_data_nxt;
  logic [3:0] read_val;
  logic [31:0] rdata_nxt;
  logic setup_ok;
  logic access;
  logic unmapped;

  // Async sources into the clock domain before any read sees them
  assign sync_in = {cmp2_out, cmp1_out, shared_pin_in};
  pcemux_sync #(.W(6)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .clk_en(clk_en),
    .async_in(sync_in),
    .sync_out(sync_q)
  );
  assign pin_s = sync_q[3:0];
  assign cmp1_s = sync_q[4];
  assign cmp2_s = sync_q[5];

  // Source of one read bit from option state
  function automatic pcemux_src_t bit_src(input logic [1:0] idx, input logic amp,
                                          input logic c1, input logic c2,
                                          input logic rz1, input logic rz3);
    pcemux_src_t s;
    s = PCEMUX_SRC_PIN;
    if (!amp && !c1 && !c2)
      s = PCEMUX_SRC_PIN;
    else if (amp && c1 && !c2)
    begin
      // Amp owns pins 2 and 3 here, so they read zero
      case (idx)
        2'd0: s = PCEMUX_SRC_CMP;
        2'd1: s = rz1 ? PCEMUX_SRC_ZERO : PCEMUX_SRC_PIN;
        default: s = PCEMUX_SRC_ZERO;
      endcase
    end
    else
    begin
      // Comparator 1 steers bit 0, comparator 2 bit 2 unless the amp is on without comparator 1; either one enables the read-zero bits
      case (idx)
        2'd0: s = c1 ? PCEMUX_SRC_CMP : PCEMUX_SRC_PIN;
        2'd1: s = ((c1 || c2) && rz1) ? PCEMUX_SRC_ZERO : PCEMUX_SRC_PIN;
        2'd2: s = (c2 && !c1 && !amp) || (c2 && c1) ? PCEMUX_SRC_CMP
                  : PCEMUX_SRC_PIN;
        default: s = ((c1 || c2) && rz3) ? PCEMUX_SRC_ZERO : PCEMUX_SRC_PIN;
      endcase
    end
    return s;
  endfunction

  // Per-bit read multiplexer, options steer it directly
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_rd
      pcemux_src_t src;
      logic cmp_v;
      assign src = bit_src(2'(gi), amp_enable_opt, cmp1_enable_opt, cmp2_enable_opt,
                           bit1_read_zero_opt, bit3_read_zero_opt);
      assign cmp_v = (gi == 0) ? cmp1_s : cmp2_s;
      // With the io option, output bits read back the latch; otherwise the bit reads the pin
      always_comb
      begin
        if (src == PCEMUX_SRC_ZERO)
          read_val[gi] = 1'b0;
        else if (src == PCEMUX_SRC_CMP)
          read_val[gi] = cmp_v;
        else if (shared_port_io_opt && shared_port_direction_r[gi])
          read_val[gi] = shared_port_data_r[gi];
        else
          read_val[gi] = pin_s[gi];
      end
    end
  endgenerate

  // APB decode
  assign setup_ok = psel && !penable;
  assign access = psel && penable;
  always_comb
  begin
    rdata_nxt = PCEMUX_ZERO_WORD;
    unmapped = 1'b0;
    if (paddr == PCEMUX_DATA_OFS)
      rdata_nxt[3:0] = read_val;
    else if (paddr == PCEMUX_DIR_OFS)
      rdata_nxt[3:0] = shared_port_direction_r;
    else if (paddr == PCEMUX_OUT_OFS)
      rdata_nxt[3:0] = shared_port_data_r;
    else if (paddr == PCEMUX_OPT_OFS)
      rdata_nxt[5:0] = {shared_port_io_opt, bit3_read_zero_opt, bit1_read_zero_opt,
                        cmp2_enable_opt, cmp1_enable_opt, amp_enable_opt};
    else
      unmapped = 1'b1;
  end

  // No wait state: answer registered at the end of setup, shown in the first access cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= PCEMUX_ZERO_WORD;
    end
    else if (clk_en)
    begin
      pready <= setup_ok;
      pslverr <= setup_ok && unmapped;
      prdata <= (setup_ok && !pwrite) ? rdata_nxt : PCEMUX_ZERO_WORD;
    end
  end

  // Register writes land at the completing edge only
  assign shared_port_data_nxt = pwdata[3:0];
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      shared_port_direction_r <= PCEMUX_DIR_RST;
      shared_port_data_r <= PCEMUX_OUT_RST;
    end
    else if (clk_en && access && pready && pwrite)
    begin
      if (paddr == PCEMUX_DIR_OFS)
        shared_port_direction_r <= pwdata[3:0];
      else if (paddr == PCEMUX_OUT_OFS)
        shared_port_data_r <= shared_port_data_nxt;
    end
  end

  // Pin drivers; analog-owned pins are never driven digitally
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      shared_pin_out <= 4'h0;
      shared_pin_oe <= 4'h0;
      amp_active <= 1'b0;
      cmp1_active <= 1'b0;
      cmp2_active <= 1'b0;
    end
    else if (clk_en)
    begin
      shared_pin_out <= shared_port_data_r;
      // Pin 1 left to software in amp mode, it is expected to be input
      shared_pin_oe <= (shared_port_io_opt ? shared_port_direction_r : 4'h0)
                       & ~(amp_enable_opt ? 4'hD : 4'h0);
      amp_active <= amp_enable_opt;
      cmp1_active <= cmp1_enable_opt;
      cmp2_active <= cmp2_enable_opt && !(amp_enable_opt && cmp1_enable_opt);
    end
  end

  // Checks
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_run;
    clk_en;
  endsequence
  sequence s_access;
    psel && penable && pready;
  endsequence
  sequence s_wr_dir;
    pwrite && paddr == PCEMUX_DIR_OFS;
  endsequence
  sequence s_wr_out;
    pwrite && paddr == PCEMUX_OUT_OFS;
  endsequence
  sequence s_rd_data;
    !pwrite && paddr == PCEMUX_DATA_OFS;
  endsequence
  sequence s_rd_opt;
    !pwrite && paddr == PCEMUX_OPT_OFS;
  endsequence
  sequence s_mapped;
    !unmapped;
  endsequence
  property p_rdy_after_setup;
    @(posedge pclk) disable iff (!presetn)
      (s_setup and s_run) ##1 s_run |-> pready;
  endproperty
  a_rdy_after_setup: assert property (p_rdy_after_setup) else $error("no pready");
  property p_plain_io;
    @(posedge pclk) disable iff (!presetn)
      (!amp_enable_opt && !cmp1_enable_opt && !cmp2_enable_opt) |->
        read_val == ((shared_port_io_opt ? shared_port_direction_r : 4'h0) & shared_port_data_r
                     | ~(shared_port_io_opt ? shared_port_direction_r : 4'h0) & pin_s);
  endproperty
  a_plain_io: assert property (p_plain_io) else $error("plain io read wrong");
  property p_cmp1_bit0;
    @(posedge pclk) disable iff (!presetn)
      cmp1_enable_opt |-> read_val[0] == cmp1_s;
  endproperty
  a_cmp1_bit0: assert property (p_cmp1_bit0) else $error("bit0 not cmp1");
  property p_bit1_read_zero_opt;
    @(posedge pclk) disable iff (!presetn)
      ((cmp1_enable_opt || cmp2_enable_opt) && bit1_read_zero_opt) |-> !read_val[1];
  endproperty
  a_bit1_read_zero_opt: assert property (p_bit1_read_zero_opt) else $error("bit1 not zero");
  property p_bit3_read_zero_opt;
    @(posedge pclk) disable iff (!presetn)
      ((cmp1_enable_opt || cmp2_enable_opt) && bit3_read_zero_opt) |-> !read_val[3];
  endproperty
  a_bit3_read_zero_opt: assert property (p_bit3_read_zero_opt) else $error("bit3 not zero");
  property p_cmp2_bit2;
    @(posedge pclk) disable iff (!presetn)
      (cmp2_enable_opt && !cmp1_enable_opt && !amp_enable_opt) |-> read_val[2] == cmp2_s;
  endproperty
  a_cmp2_bit2: assert property (p_cmp2_bit2) else $error("bit2 not cmp2");
  property p_amp_cmp;
    @(posedge pclk) disable iff (!presetn)
      (amp_enable_opt && cmp1_enable_opt && !cmp2_enable_opt) |-> read_val[3:2] == 2'b00;
  endproperty
  a_amp_cmp: assert property (p_amp_cmp) else $error("bits 3,2 not zero");
  property p_sync_delay;
    @(posedge pclk) disable iff (!presetn)
      (presetn && clk_en) ##1 clk_en |=> pin_s == $past(shared_pin_in, 2);
  endproperty
  a_sync_delay: assert property (p_sync_delay) else $error("sync depth wrong");
  property p_amp_no_drive;
    @(posedge pclk) disable iff (!presetn)
      (amp_enable_opt && clk_en) |=> (shared_pin_oe & 4'hD) == 4'h0;
  endproperty
  a_amp_no_drive: assert property (p_amp_no_drive) else $error("amp pin driven");
  property p_rdy_pulse;
    @(posedge pclk) disable iff (!presetn)
      (pready && penable && clk_en) |=> !pready;
  endproperty
  a_rdy_pulse: assert property (p_rdy_pulse) else $error("pready longer than one cycle");
  property p_err_unmapped;
    @(posedge pclk) disable iff (!presetn)
      (s_setup and s_run) ##0 unmapped |=> pready && pslverr;
  endproperty
  a_err_unmapped: assert property (p_err_unmapped) else $error("no error on unmapped");
  property p_no_err_mapped;
    @(posedge pclk) disable iff (!presetn)
      (s_setup and s_run and s_mapped) |=> pready && !pslverr;
  endproperty
  a_no_err_mapped: assert property (p_no_err_mapped) else $error("error on mapped");
  property p_rdata_idle;
    @(posedge pclk) disable iff (!presetn)
      !pready |-> prdata == PCEMUX_ZERO_WORD;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside answer");
  property p_rd_data;
    @(posedge pclk) disable iff (!presetn)
      (s_setup and s_run and s_rd_data) |=> prdata == {28'h0, $past(read_val)};
  endproperty
  a_rd_data: assert property (p_rd_data) else $error("port read data wrong");
  property p_rd_opt;
    @(posedge pclk) disable iff (!presetn)
      (s_setup and s_run and s_rd_opt) |=>
        prdata == {26'h0, shared_port_io_opt, bit3_read_zero_opt, bit1_read_zero_opt,
                   cmp2_enable_opt, cmp1_enable_opt, amp_enable_opt};
  endproperty
  a_rd_opt: assert property (p_rd_opt) else $error("option readback wrong");
  property p_wr_dir;
    @(posedge pclk) disable iff (!presetn)
      (s_access and s_run and s_wr_dir) |=>
        {28'h0, shared_port_direction_r} == ($past(pwdata) & 32'h0000_000F);
  endproperty
  a_wr_dir: assert property (p_wr_dir) else $error("direction write lost");
  property p_wr_out;
    @(posedge pclk) disable iff (!presetn)
      (s_access and s_run and s_wr_out) |=>
        {28'h0, shared_port_data_r} == ($past(pwdata) & 32'h0000_000F);
  endproperty
  a_wr_out: assert property (p_wr_out) else $error("output latch write lost");
  property p_dir_hold;
    @(posedge pclk) disable iff (!presetn)
      !(clk_en && psel && penable && pready && pwrite) |=> $stable(shared_port_direction_r);
  endproperty
  a_dir_hold: assert property (p_dir_hold) else $error("direction changed unasked");
  property p_out_follow;
    @(posedge pclk) disable iff (!presetn)
      clk_en |=> shared_pin_out == $past(shared_port_data_r);
  endproperty
  a_out_follow: assert property (p_out_follow) else $error("pin out not latch");
  property p_oe_dir;
    @(posedge pclk) disable iff (!presetn)
      (clk_en && shared_port_io_opt && !amp_enable_opt) |=>
        shared_pin_oe == $past(shared_port_direction_r);
  endproperty
  a_oe_dir: assert property (p_oe_dir) else $error("enable not direction");
  property p_amp_alone;
    @(posedge pclk) disable iff (!presetn)
      (amp_enable_opt && !cmp1_enable_opt && !cmp2_enable_opt) |->
        read_val == ((shared_port_io_opt ? shared_port_direction_r : 4'h0) & shared_port_data_r
                     | ~(shared_port_io_opt ? shared_port_direction_r : 4'h0) & pin_s);
  endproperty
  a_amp_alone: assert property (p_amp_alone) else $error("amp alone read wrong");
  property p_cmp2_off_amp;
    @(posedge pclk) disable iff (!presetn)
      (clk_en && amp_enable_opt && cmp1_enable_opt) |=> !cmp2_active;
  endproperty
  a_cmp2_off_amp: assert property (p_cmp2_off_amp) else $error("cmp2 active with amp");
endmodule // pcemux_top
`default_nettype wire

// ### testbench/pcemux_env.sv
// Partner model: option straps and the pin environment
`default_nettype none
module pcemux_env
  import pcemux_pkg::*;
(
  // Requested straps
  input wire logic [5:0] opt_req,
  // Pin side
  input wire logic [3:0] ext_lvl,
  input wire logic [3:0] pin_out,
  input wire logic [3:0] pin_oe,
  output logic [3:0] pin_lvl,
  // Straps toward the port
  output logic [5:0] opt
);
  timeunit 1ns;
  timeprecision 1ps;
  // Comparator 2 kept off whenever the amplifier is on, the safe reading
  always_comb
  begin
    opt = opt_req;
    opt[PCEMUX_OPT_CMP2_BIT] = opt_req[PCEMUX_OPT_CMP2_BIT] & ~opt_req[PCEMUX_OPT_AMP_BIT];
  end
  // Driven pins show the latch, the others the outside source
  assign pin_lvl = (pin_out & pin_oe) | (ext_lvl & ~pin_oe);
endmodule // pcemux_env
`default_nettype wire

// ### testbench/pcemux_top_tb.sv
// Self-checking bench for the shared port read mux
`default_nettype none
module pcemux_top_tb;
  import pcemux_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rd;
  logic pready, pslverr, er, amp_a, c1_a, c2_a;
  logic c1 = 1'b0;
  logic c2 = 1'b0;
  logic ce = 1'b1;
  logic [3:0] ext = 4'h0;
  logic [5:0] opt_req = 6'h00;
  logic [5:0] opt;
  logic [3:0] pin_lvl, pin_out, pin_oe;
  int err_count = 0;
  int checked = 0;
  int cyc = 0;

  initial
  begin
    forever #2.5 pclk = ~pclk;
  end

  pcemux_env env_u (.opt_req(opt_req), .ext_lvl(ext), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_lvl(pin_lvl), .opt(opt));

  pcemux_top dut_u (.pclk(pclk), .presetn(presetn), .clk_en(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .amp_enable_opt(opt[0]), .cmp1_enable_opt(opt[1]),
    .cmp2_enable_opt(opt[2]), .bit1_read_zero_opt(opt[3]), .bit3_read_zero_opt(opt[4]),
    .shared_port_io_opt(opt[5]), .cmp1_out(c1), .cmp2_out(c2), .shared_pin_in(pin_lvl),
    .shared_pin_out(pin_out), .shared_pin_oe(pin_oe), .amp_active(amp_a),
    .cmp1_active(c1_a), .cmp2_active(c2_a));

  task automatic stop_test();
    $display("checked %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("FAIL %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  // Request held until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Straps only change while reset is held
  task automatic restart(input logic [5:0] o);
    presetn <= 1'b0;
    opt_req <= o;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
  endtask

  function automatic logic [3:0] exp_rd(input logic [5:0] o, input logic [3:0] p,
    input logic k1, input logic k2);
    logic anyc, ac;
    anyc = o[1] | o[2];
    ac = o[0] & o[1];
    exp_rd[0] = o[1] ? k1 : p[0];
    exp_rd[1] = (anyc & o[3]) ? 1'b0 : p[1];
    exp_rd[2] = ac ? 1'b0 : (o[2] ? k2 : p[2]);
    exp_rd[3] = (ac | (anyc & o[4])) ? 1'b0 : p[3];
  endfunction

  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 6000)
    begin
      err_count++;
      stop_test();
    end
  end

  initial
  begin
    void'($urandom(32'h38a0));
    for (int i = 0; i < 32; i++)
    begin
      restart({1'b1, i[4:0]});
      @(negedge pclk);
      chk({29'h0, amp_a, c1_a, c2_a}, {29'h0, opt[0], opt[1], opt[2]}, "active");
      repeat (4)
      begin
        @(posedge pclk);
        ext <= 4'($urandom);
        c1 <= 1'($urandom);
        c2 <= 1'($urandom);
        // Two sync flops plus margin before the sample
        repeat (4) @(posedge pclk);
        apb(1'b0, PCEMUX_DATA_OFS, 32'h0000_0000);
        chk(rd, {28'h0, exp_rd(opt, ext, c1, c2)}, "read mux");
      end
    end
    $display("test read mux done");
    restart(6'h20);
    apb(1'b1, PCEMUX_DIR_OFS, 32'h0000_000F);
    apb(1'b1, PCEMUX_OUT_OFS, 32'h0000_0005);
    repeat (2) @(negedge pclk);
    chk({24'h0, pin_oe, pin_out}, 32'h0000_00F5, "dir out");
    apb(1'b0, PCEMUX_DIR_OFS, 32'h0000_0000);
    chk(rd, 32'h0000_000F, "dir readback");
    apb(1'b0, PCEMUX_OPT_OFS, 32'h0000_0000);
    chk(rd, 32'h0000_0020, "opt readback");
    apb(1'b1, 12'h010, 32'h0000_0003);
    chk({31'h0, er}, 32'h0000_0001, "unmapped");
    restart(6'h00);
    apb(1'b1, PCEMUX_DIR_OFS, 32'h0000_000F);
    repeat (2) @(negedge pclk);
    chk({28'h0, pin_oe}, 32'h0000_0000, "no io opt");
    @(posedge pclk);
    restart(6'h21);
    apb(1'b1, PCEMUX_DIR_OFS, 32'h0000_000D);
    repeat (2) @(negedge pclk);
    chk({28'h0, pin_oe}, 32'h0000_0000, "amp pins");
    @(posedge pclk);
    ce <= 1'b0;
    restart(6'h01);
    @(negedge pclk);
    chk({31'h0, amp_a}, 32'h0000_0000, "frozen");
    @(posedge pclk);
    ce <= 1'b1;
    repeat (2) @(negedge pclk);
    chk({31'h0, amp_a}, 32'h0000_0001, "thawed");
    $display("test direction done");
    stop_test();
  end
endmodule // pcemux_top_tb
`default_nettype wire
